// [flash_model.sv]
// Purpose: flash macro stand-in that acknowledges commands
// Assumes: one command at a time, on the system clock
// Notes:   DLY sets how slowly the macro answers
`timescale 1ns/1ps
module flash_model
    import mem_prot_pkg::*;
#(
    parameter int DLY = 3
)(
    // clock and command
    input wire logic i_ref_clk,
    input wire flash_cmd_t i_cmd,
    // acknowledge
    output logic o_done
);
    int cnt_ff = 0;
    // count down from each command, pulse done on the last step
    always_ff @(posedge i_ref_clk)
    begin
        if (i_cmd.valid)
            cnt_ff <= DLY;
        else if (cnt_ff > 0)
            cnt_ff <= cnt_ff - 1;
    end
    assign o_done = (cnt_ff == 1);
endmodule // flash_model

// [mem_prot.sv]
// Purpose: data space decode, access timing, nvm protection and locks
// Assumes: masters hold a request until its done pulse; flash macro
//          acknowledges each command with i_flash_done
// Notes:   master 0 (cpu) wins a region over 1 (dma read) and 2 (dma write)
`timescale 1ns/1ps
module mem_prot
    import mem_prot_pkg::*;
#(
    parameter int SRAM_BYTES = 8192,
    parameter logic [3:0] EXT_LAT = 4'h4,
    parameter int FUSE_N = 6,
    parameter int PSIG_N = 64,
    parameter int USIG_N = 512,
    parameter int CAL_N = 4,
    parameter logic [23:0] DEV_ID = 24'h5A0A01, // arbitrary value
    parameter logic [7:0] DEV_REV = 8'h01, // arbitrary value
    parameter logic [19:0] PROT_LO = 20'h00040,
    parameter logic [19:0] PROT_HI = 20'h0007F
)(
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_we,
    input wire logic i_reg_re,
    output logic [7:0] o_reg_rdata,
    // data space masters: 0 cpu, 1 dma read, 2 dma write
    input wire acc_req_t [2:0] i_acc,
    output acc_rsp_t [2:0] o_acc,
    // self-program, programmer, flash macro
    input wire spm_req_t i_spm,
    input wire prog_req_t i_prog,
    input wire logic i_ccp_open,
    input wire logic [8*PSIG_N-1:0] i_psig,
    input wire logic i_flash_done,
    output flash_cmd_t o_flash_cmd,
    output logic [7:0] o_prog_rdata,
    // module outputs
    output logic [8*CAL_N-1:0] o_cal,
    output logic o_tap_block,
    output logic o_tap_pins_gpio
);

    localparam logic [19:0] SRAM_END = SRAM_BASE + 20'(SRAM_BYTES - 1);

    acc_rsp_t [2:0] rsp_ff;
    logic [2:0][3:0] cnt_ff;
    logic [15:0][7:0] gpr_ff;
    logic [7:0] rdata_ff, prog_rdata_ff, lock_ff, status_ff, sig_idx_ff;
    logic [FUSE_N-1:0][7:0] fuse_ff;
    logic [USIG_N-1:0][7:0] usig_ff;
    logic [8*CAL_N-1:0] cal_ff;
    logic ee_map_ff, tap_dis_ff, iolock_ff;
    ce_state_t ce_ff, nxt_ce;
    flash_cmd_t flash_ff;
    logic [2:0] take;
    region_t [2:0] reg_of;
    logic [2:0] bad;

    // region decode shared by all three masters
    function automatic region_t decode(input logic [19:0] a, input logic em);
        if (a <= IO_END)
            decode = REG_IO;
        else if (a <= EE_END)
            decode = em ? REG_EE : REG_RESV;
        else if (a < SRAM_BASE)
            decode = REG_RESV;
        else if (a <= SRAM_END)
            decode = REG_SRAM;
        else
            decode = REG_EXT;
    endfunction

    function automatic logic [3:0] latency(input region_t r,
        input logic wr, input logic bu);
        case (r)
            REG_IO: latency = LAT_IO;
            REG_SRAM: latency = wr ? LAT_SRAM_WR :
                (bu ? LAT_SRAM_BURST : LAT_SRAM_RD);
            REG_EE: latency = wr ? LAT_EE_WR :
                (bu ? LAT_EE_BURST : LAT_EE_RD);
            REG_EXT: latency = EXT_LAT;
            default: latency = LAT_ERR;
        endcase
    endfunction

    // accept a request when idle and no higher master takes the same region in the same cycle
    always_comb
    begin
        for (int m = 0; m < 3; m++)
        begin
            reg_of[m] = decode(i_acc[m].addr, ee_map_ff);
            bad[m] = (i_acc[m].short_io && i_acc[m].addr > SHORT_IO_END)
                || (i_acc[m].op != OP_PLAIN && i_acc[m].addr > BIT_IO_END)
                || (i_acc[m].write && iolock_ff && i_acc[m].addr >= PROT_LO
                    && i_acc[m].addr <= PROT_HI);
            take[m] = i_acc[m].valid && cnt_ff[m] == 4'h0
                && !rsp_ff[m].done;
            for (int h = 0; h < m; h++)
                if (take[h] && reg_of[h] == reg_of[m])
                    take[m] = 1'b0;
        end
    end

    // per-master latency counter and answer
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            rsp_ff <= '0;
            cnt_ff <= '0;
        end
        else if (i_ce)
        begin
            for (int m = 0; m < 3; m++)
            begin
                rsp_ff[m].done <= cnt_ff[m] == 4'h1;
                if (take[m])
                begin
                    cnt_ff[m] <= bad[m] ? LAT_ERR :
                        latency(reg_of[m], i_acc[m].write, i_acc[m].burst);
                    rsp_ff[m].err <= bad[m];
                    rsp_ff[m].region <= reg_of[m];
                    if (reg_of[m] == REG_RESV)
                        rsp_ff[m].rdata <= RESV_RD_VALUE;
                    else if (i_acc[m].addr <= GPR_END)
                        rsp_ff[m].rdata <= (i_acc[m].op == OP_BTEST) ?
                            {7'h00, gpr_ff[i_acc[m].addr[3:0]]
                                [i_acc[m].bit_idx]} :
                            gpr_ff[i_acc[m].addr[3:0]];
                    else
                        rsp_ff[m].rdata <= 8'h00;
                end
                else if (cnt_ff[m] != 4'h0)
                    cnt_ff[m] <= cnt_ff[m] - 4'h1;
            end
        end
    end

    // general purpose registers; region arbitration keeps writers apart
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            gpr_ff <= '0;
        else if (i_ce)
        begin
            for (int m = 0; m < 3; m++)
                if (take[m] && !bad[m] && i_acc[m].addr <= GPR_END)
                    case (i_acc[m].op)
                        OP_PLAIN:
                            if (i_acc[m].write)
                                gpr_ff[i_acc[m].addr[3:0]] <= i_acc[m].wdata;
                        OP_BSET: gpr_ff[i_acc[m].addr[3:0]]
                            [i_acc[m].bit_idx] <= 1'b1;
                        OP_BCLR: gpr_ff[i_acc[m].addr[3:0]]
                            [i_acc[m].bit_idx] <= 1'b0;
                        default: ;
                    endcase
        end
    end

    // control bits; the lock itself only moves under change protection
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            ee_map_ff <= 1'b0;
            tap_dis_ff <= 1'b0;
            iolock_ff <= 1'b0;
            sig_idx_ff <= '0;
        end
        else if (i_ce && i_reg_we)
        begin
            if (i_reg_addr == OFS_CTRL)
            begin
                ee_map_ff <= i_reg_wdata[CTRL_EEMAP];
                tap_dis_ff <= i_reg_wdata[CTRL_TAPDIS];
            end
            if (i_reg_addr == OFS_IOLOCK && i_ccp_open)
                iolock_ff <= i_reg_wdata[0];
            if (i_reg_addr == OFS_SIG_IDX)
                sig_idx_ff <= i_reg_wdata;
        end
    end

    // protection bits: writes can only clear, chip erase sets them last
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            lock_ff <= LOCK_RST;
        else if (i_ce)
        begin
            if (ce_ff == CE_LOCK && i_flash_done)
                lock_ff <= LOCK_RST;
            else
                lock_ff <= lock_ff
                    & ((i_reg_we && i_reg_addr == OFS_LOCKBITS) ?
                        i_reg_wdata : 8'hFF)
                    & ((i_prog.valid && i_prog.cmd == PG_WR_LOCK) ?
                        i_prog.data : 8'hFF);
        end
    end

    // fuses: the programmer is the only writer
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            fuse_ff <= {FUSE_N{FUSE_RST}};
        else if (i_ce && i_prog.valid && i_prog.cmd == PG_WR_FUSE
            && i_prog.idx < 9'(FUSE_N))
            fuse_ff[i_prog.idx] <= i_prog.data;
    end

    // user row: chip erase never touches it, only its own erase
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            usig_ff <= {USIG_N{ERASED_BYTE}};
        else if (i_ce)
        begin
            if (i_prog.valid && i_prog.cmd == PG_ERASE_USIG)
                usig_ff <= {USIG_N{ERASED_BYTE}};
            else if (i_prog.valid && i_prog.cmd == PG_WR_USIG
                && i_prog.idx < 9'(USIG_N))
                usig_ff[i_prog.idx] <= i_prog.data;
            else if (i_reg_we && i_reg_addr == OFS_USIG_DATA)
                usig_ff[sig_idx_ff] <= i_reg_wdata;
        end
    end

    // calibration bytes picked up while reset is held
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            cal_ff <= i_psig[8*CAL_N-1:0];
    end

    // chip erase sequence; each step waits for the flash acknowledge
    always_comb
    begin
        nxt_ce = ce_ff;
        case (ce_ff)
            CE_IDLE:
                if (i_prog.valid && i_prog.cmd == PG_CHIP_ERASE)
                    nxt_ce = CE_APP;
            CE_APP:
                if (i_flash_done)
                    nxt_ce = CE_BOOT;
            CE_BOOT:
                if (i_flash_done)
                    nxt_ce = CE_LOCK;
            CE_LOCK:
                if (i_flash_done)
                    nxt_ce = CE_IDLE;
            default: nxt_ce = CE_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            ce_ff <= CE_IDLE;
        else if (i_ce)
            ce_ff <= nxt_ce;
    end

    // write protection of the section that holds a flash word address
    function automatic logic wr_locked(input logic [16:0] a,
        input logic [7:0] lk);
        if (a >= BOOT_BASE)
            wr_locked = !lk[LOCK_BOOT_WR];
        else if (a >= BOOT_BASE - 17'h01000)
            wr_locked = !lk[LOCK_TBL_WR];
        else
            wr_locked = !lk[LOCK_APP_WR];
    endfunction

    logic spm_ok;
    // boot-resident code may reach every section whose write lock bit is set, its own section too
    assign spm_ok = i_spm.valid && i_spm.fetch_pc >= BOOT_BASE
        && !wr_locked(i_spm.target, lock_ff) && ce_ff == CE_IDLE;

    // flash command pulses: erase steps first, then self-program
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            flash_ff <= '0;
        else if (i_ce)
        begin
            flash_ff <= '0;
            if (nxt_ce != ce_ff && nxt_ce == CE_APP)
                flash_ff <= '{1'b1, FL_ERASE_SECT, APP_BASE};
            else if (nxt_ce != ce_ff && nxt_ce == CE_BOOT)
                flash_ff <= '{1'b1, FL_ERASE_SECT, BOOT_BASE};
            else if (nxt_ce != ce_ff && nxt_ce == CE_LOCK)
                flash_ff <= '{1'b1, FL_ERASE_PAGE, 17'h1FFFF}; // lock row
            else if (spm_ok)
                flash_ff <= '{1'b1, i_spm.op, i_spm.target};
        end
    end

    // sticky rejects; a new reject wins over a clear in the same cycle
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            status_ff <= '0;
        else if (i_ce)
        begin
            if (i_reg_we && i_reg_addr == OFS_STATUS)
                status_ff <= status_ff & ~i_reg_wdata;
            status_ff[ST_CE_BUSY] <= nxt_ce != CE_IDLE;
            if ((i_prog.valid && i_prog.cmd == PG_WR_PSIG)
                || (i_reg_we && i_reg_addr == OFS_PSIG_DATA))
                status_ff[ST_SIG_REJ] <= 1'b1;
            if (i_reg_we && i_reg_addr == OFS_FUSE_DATA)
                status_ff[ST_FUSE_REJ] <= 1'b1;
            if (i_spm.valid && !spm_ok)
                status_ff[ST_SPM_REJ] <= 1'b1;
        end
    end

    // register reads and programmer reads
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            rdata_ff <= '0;
            prog_rdata_ff <= '0;
        end
        else if (i_ce)
        begin
            rdata_ff <= '0;
            if (i_reg_re)
                case (i_reg_addr)
                    OFS_CTRL: rdata_ff <= {6'h00, tap_dis_ff, ee_map_ff};
                    OFS_IOLOCK: rdata_ff <= {7'h00, iolock_ff};
                    OFS_LOCKBITS: rdata_ff <= lock_ff;
                    OFS_STATUS: rdata_ff <= status_ff;
                    OFS_ID0: rdata_ff <= DEV_ID[7:0];
                    OFS_ID1: rdata_ff <= DEV_ID[15:8];
                    OFS_ID2: rdata_ff <= DEV_ID[23:16];
                    OFS_REV: rdata_ff <= DEV_REV;
                    OFS_PSIG_DATA: rdata_ff <= (sig_idx_ff < 8'(PSIG_N)) ?
                        i_psig[8*sig_idx_ff +: 8] : 8'h00;
                    OFS_USIG_DATA: rdata_ff <= usig_ff[sig_idx_ff];
                    OFS_FUSE_DATA: rdata_ff <= (sig_idx_ff < 8'(FUSE_N)) ?
                        fuse_ff[sig_idx_ff] : 8'h00;
                    default: rdata_ff <= 8'h00;
                endcase
            if (i_prog.valid && i_prog.cmd == PG_READ)
                prog_rdata_ff <= (i_prog.idx < 9'(PSIG_N)) ?
                    i_psig[8*i_prog.idx +: 8] : usig_ff[i_prog.idx];
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_acc = rsp_ff;
    assign o_flash_cmd = flash_ff;
    assign o_prog_rdata = prog_rdata_ff;
    assign o_cal = cal_ff;
    assign o_tap_block = tap_dis_ff;
    assign o_tap_pins_gpio = tap_dis_ff;

    // checks
    sequence s_sram_rd(m);
        take[m] && !bad[m] && reg_of[m] == REG_SRAM && !i_acc[m].write
            && !i_acc[m].burst && i_ce;
    endsequence
    sequence s_ee_rd;
        take[0] && !bad[0] && reg_of[0] == REG_EE && !i_acc[0].write
            && !i_acc[0].burst && i_ce;
    endsequence

    a_sram_rd_lat: assert property (@(posedge i_ref_clk) disable iff
        (!i_rst_n) s_sram_rd(0) ##1 i_ce [*3] |-> rsp_ff[0].done)
        else $error("sram read not done after two cycles");
    a_ee_rd_lat: assert property (@(posedge i_ref_clk) disable iff
        (!i_rst_n) s_ee_rd ##1 i_ce [*4] |-> rsp_ff[0].done
            && !$past(rsp_ff[0].done))
        else $error("eeprom read not done after three cycles");
    a_spm_boot_only: assert property (@(posedge i_ref_clk) disable iff
        (!i_rst_n) i_ce && i_spm.valid && i_spm.fetch_pc < BOOT_BASE
            && ce_ff == CE_IDLE && nxt_ce == CE_IDLE |=> !flash_ff.valid)
        else $error("self-program started outside boot");
    a_lock_stricter: assert property (@(posedge i_ref_clk) disable iff
        (!i_rst_n) ce_ff != CE_LOCK |=> (lock_ff & ~$past(lock_ff)) == 8'h00)
        else $error("protection loosened outside chip erase");
    a_lock_after_erase: assert property (@(posedge i_ref_clk) disable iff
        (!i_rst_n) $rose(lock_ff != 8'h00 && lock_ff == LOCK_RST)
            |-> $past(ce_ff) == CE_LOCK)
        else $error("protection cleared before flash erase");
    a_fuse_sw_write: assert property (@(posedge i_ref_clk) disable iff
        (!i_rst_n) !(i_prog.valid && i_prog.cmd == PG_WR_FUSE)
            |=> fuse_ff == $past(fuse_ff))
        else $error("fuse changed without programmer");
    a_resv_rdata: assert property (@(posedge i_ref_clk) disable iff
        (!i_rst_n) take[1] && reg_of[1] == REG_RESV && i_ce
            |=> rsp_ff[1].rdata == RESV_RD_VALUE)
        else $error("reserved read value wrong");
    a_io_lock_gate: assert property (@(posedge i_ref_clk) disable iff
        (!i_rst_n) i_ce && i_reg_we && i_reg_addr == OFS_IOLOCK
            && !i_ccp_open |=> iolock_ff == $past(iolock_ff))
        else $error("i/o lock changed without protection");
    a_bitop_range: assert property (@(posedge i_ref_clk) disable iff
        (!i_rst_n) take[0] && i_ce && i_acc[0].op != OP_PLAIN
            && i_acc[0].addr > BIT_IO_END |=> rsp_ff[0].err ##1
            rsp_ff[0].done)
        else $error("bit operation above 0x1F accepted");
    a_concurrent: assert property (@(posedge i_ref_clk) disable iff
        (!i_rst_n) i_acc[0].valid && i_acc[1].valid && cnt_ff[1] == 4'h0
            && !rsp_ff[1].done && reg_of[0] != reg_of[1] |-> take[1])
        else $error("master stalled on a free region");

endmodule // mem_prot

// [mem_prot_pkg.sv]
// Purpose: shared constants and types for the memory map and nvm protection
// Assumes: one system clock; all masters and the flash macro on that clock
// Notes:   data addresses are 20 bits, flash word addresses 17 bits
package mem_prot_pkg;

    // data space map
    localparam logic [19:0] IO_END = 20'h00FFF;
    localparam logic [19:0] EE_BASE = 20'h01000;
    localparam logic [19:0] EE_END = 20'h017FF;
    localparam logic [19:0] SRAM_BASE = 20'h02000;
    localparam logic [19:0] EXT_END = 20'hFFFFF;
    localparam logic [19:0] SHORT_IO_END = 20'h0003F;
    localparam logic [19:0] BIT_IO_END = 20'h0001F;
    localparam logic [19:0] GPR_END = 20'h0000F;
    localparam logic [7:0] RESV_RD_VALUE = 8'h00;

    // access latencies in cycles
    localparam logic [3:0] LAT_IO = 4'h1;
    localparam logic [3:0] LAT_SRAM_WR = 4'h1;
    localparam logic [3:0] LAT_SRAM_RD = 4'h2;
    localparam logic [3:0] LAT_SRAM_BURST = 4'h1;
    localparam logic [3:0] LAT_EE_WR = 4'h1;
    localparam logic [3:0] LAT_EE_RD = 4'h3;
    localparam logic [3:0] LAT_EE_BURST = 4'h2;
    localparam logic [3:0] LAT_ERR = 4'h1;

    // flash word addresses of the sections
    localparam logic [16:0] APP_BASE = 17'h00000;
    localparam logic [16:0] BOOT_BASE = 17'h10000;

    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IOLOCK = 8'h01;
    localparam logic [7:0] OFS_LOCKBITS = 8'h02;
    localparam logic [7:0] OFS_STATUS = 8'h03;
    localparam logic [7:0] OFS_ID0 = 8'h04;
    localparam logic [7:0] OFS_ID1 = 8'h05;
    localparam logic [7:0] OFS_ID2 = 8'h06;
    localparam logic [7:0] OFS_REV = 8'h07;
    localparam logic [7:0] OFS_SIG_IDX = 8'h08;
    localparam logic [7:0] OFS_PSIG_DATA = 8'h09;
    localparam logic [7:0] OFS_USIG_DATA = 8'h0A;
    localparam logic [7:0] OFS_FUSE_DATA = 8'h0B;

    // field positions and reset values
    localparam int CTRL_EEMAP = 0;
    localparam int CTRL_TAPDIS = 1;
    localparam int ST_CE_BUSY = 0;
    localparam int ST_SIG_REJ = 1;
    localparam int ST_FUSE_REJ = 2;
    localparam int ST_SPM_REJ = 3;
    localparam int LOCK_APP_WR = 0;
    localparam int LOCK_TBL_WR = 2;
    localparam int LOCK_BOOT_WR = 4;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    localparam logic [7:0] FUSE_RST = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    typedef enum logic [2:0] {
        REG_IO = 3'h0, REG_EE = 3'h1, REG_SRAM = 3'h2,
        REG_EXT = 3'h3, REG_RESV = 3'h4
    } region_t;
    typedef enum logic [1:0] {
        OP_PLAIN = 2'h0, OP_BSET = 2'h1, OP_BCLR = 2'h2, OP_BTEST = 2'h3
    } acc_op_t;
    typedef enum logic [1:0] {
        FL_NONE = 2'h0, FL_WRITE = 2'h1, FL_ERASE_PAGE = 2'h2,
        FL_ERASE_SECT = 2'h3
    } flash_op_t;
    typedef enum logic [2:0] {
        PG_NOP = 3'h0, PG_WR_FUSE = 3'h1, PG_WR_LOCK = 3'h2,
        PG_CHIP_ERASE = 3'h3, PG_ERASE_USIG = 3'h4, PG_WR_USIG = 3'h5,
        PG_WR_PSIG = 3'h6, PG_READ = 3'h7
    } prog_cmd_t;
    typedef enum logic [1:0] {
        CE_IDLE = 2'h0, CE_APP = 2'h1, CE_BOOT = 2'h2, CE_LOCK = 2'h3
    } ce_state_t;

    typedef struct packed {
        logic valid; logic write; logic burst; logic short_io;
        acc_op_t op; logic [2:0] bit_idx; logic [19:0] addr;
        logic [7:0] wdata;
    } acc_req_t;
    typedef struct packed {
        logic done; logic err; region_t region; logic [7:0] rdata;
    } acc_rsp_t;
    typedef struct packed {
        logic valid; flash_op_t op; logic [16:0] addr;
    } flash_cmd_t;
    typedef struct packed {
        logic valid; logic [16:0] fetch_pc; flash_op_t op;
        logic [16:0] target;
    } spm_req_t;
    typedef struct packed {
        logic valid; prog_cmd_t cmd; logic [8:0] idx; logic [7:0] data;
    } prog_req_t;

endpackage

// [tb.sv]
// Purpose: self-checking bench for the memory map and nvm protection
// Assumes: cpu port only; dma ports held idle
// Notes:   identity values are arbitrary
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    error_cnt++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
    import mem_prot_pkg::*;
    localparam logic [23:0] ID = 24'h3C2B1A; // arbitrary value
    localparam logic [7:0] REV = 8'h05; // arbitrary value
    localparam logic [3:0] EXT_L = 4'h4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic ccp = 1'b0;
    logic tapb;
    logic tapg;
    logic [7:0] prd;
    logic [31:0] cal;
    logic fdone;
    logic [7:0] ra = 8'h00;
    logic [7:0] rw = 8'h00;
    logic [7:0] rdat;
    logic [7:0] rd_v;
    acc_req_t [2:0] acc = '0;
    acc_rsp_t [2:0] rsp;
    spm_req_t self_program_instruction = '0;
    prog_req_t prog = '0;
    flash_cmd_t fc;
    int error_cnt = 0;
    int samples_checked = 0;
    int n;
    // register rows: offset, expected read
    logic [15:0] rt [7] = '{{OFS_ID0, ID[7:0]}, {OFS_ID1, ID[15:8]},
        {OFS_ID2, ID[23:16]}, {OFS_REV, REV}, {OFS_LOCKBITS, LOCK_RST},
        {OFS_FUSE_DATA, FUSE_RST}, {8'h0F, 8'h00}};
    // access rows: address, write, region, latency
    logic [27:0] at [8] = '{{20'h00010, 1'h0, REG_IO, LAT_IO},
        {EE_BASE, 1'h0, REG_EE, LAT_EE_RD}, {EE_END, 1'h1, REG_EE, LAT_EE_WR},
        {20'h01800, 1'h0, REG_RESV, LAT_ERR},
        {20'h03FFF, 1'h0, REG_SRAM, LAT_SRAM_RD},
        {SRAM_BASE, 1'h1, REG_SRAM, LAT_SRAM_WR},
        {20'h04000, 1'h0, REG_EXT, EXT_L}, {EXT_END, 1'h1, REG_EXT, EXT_L}};
    mem_prot #(.EXT_LAT(EXT_L), .DEV_ID(ID), .DEV_REV(REV)) uut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
        .i_reg_addr(ra), .i_reg_wdata(rw), .i_reg_we(we), .i_reg_re(re),
        .o_reg_rdata(rdat), .i_acc(acc), .o_acc(rsp), .i_spm(self_program_instruction),
        .i_prog(prog), .i_ccp_open(ccp), .i_psig({64{8'hA5}}),
        .i_flash_done(fdone), .o_flash_cmd(fc), .o_prog_rdata(prd),
        .o_cal(cal), .o_tap_block(tapb), .o_tap_pins_gpio(tapg));
    flash_model #(.DLY(3)) fm (.i_ref_clk(clk), .i_cmd(fc), .o_done(fdone));
    // free-running system clock
    initial
    begin
        forever #4 clk = ~clk;
    end
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        ra <= a;
        rw <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        ra <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 rd_v = rdat;
    endtask
    // latency counted from the take edge to the done pulse
    task automatic access(input logic [27:0] r);
        @(posedge clk);
        acc[0] <= '{1'b1, r[7], 1'b0, 1'b0, OP_PLAIN, 3'h0, r[27:8], 8'h5A};
        @(posedge clk);
        n = 0;
        do begin @(posedge clk); #1; n++; end
        while (rsp[0].done !== 1'b1 && n < 20);
        `CHK(n[3:0], r[3:0])
        `CHK({rsp[0].region, rsp[0].rdata}, {r[6:4], 8'h00})
        @(posedge clk);
        acc[0].valid <= 1'b0;
    endtask
    task automatic spm_go(input logic [16:0] pc, t, input logic ok);
        @(posedge clk);
        self_program_instruction <= '{1'b1, pc, FL_WRITE, t};
        @(posedge clk);
        self_program_instruction.valid <= 1'b0;
        #1 `CHK({fc.valid, fc.addr & {17{ok}}}, {ok, t & {17{ok}}})
        repeat (6) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // main sequence: tables first, then the awkward cases
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rt[i]) begin rreg(rt[i][15:8]); `CHK(rd_v, rt[i][7:0]) end
        wreg(OFS_CTRL, 8'h01);
        foreach (at[i]) access(at[i]);
        wreg(OFS_FUSE_DATA, 8'h00);
        rreg(OFS_FUSE_DATA); `CHK(rd_v, FUSE_RST)
        wreg(OFS_LOCKBITS, 8'hFE);
        wreg(OFS_LOCKBITS, 8'hFF);
        rreg(OFS_LOCKBITS); `CHK(rd_v, 8'hFE)
        `CHK(cal, {4{8'hA5}})
        // the lock must refuse a write while change protection is shut
        wreg(OFS_IOLOCK, 8'h01);
        rreg(OFS_IOLOCK); `CHK(rd_v, 8'h00)
        ccp <= 1'b1;
        wreg(OFS_IOLOCK, 8'h01);
        ccp <= 1'b0;
        rreg(OFS_IOLOCK); `CHK(rd_v, 8'h01)
        wreg(OFS_CTRL, 8'h03);
        #1 `CHK({tapb, tapg}, 2'b11)
        prog <= '{1'b1, PG_READ, 9'h000, 8'h00};
        @(posedge clk);
        prog.valid <= 1'b0;
        #1 `CHK(prd, 8'hA5)
        spm_go(17'h0FFFF, BOOT_BASE, 1'b0);
        spm_go(BOOT_BASE, 17'h00100, 1'b0);
        spm_go(17'h10010, 17'h10FFF, 1'b1);
        @(posedge clk);
        prog <= '{1'b1, PG_CHIP_ERASE, 9'h000, 8'h00};
        @(posedge clk);
        prog.valid <= 1'b0;
        #1 `CHK({fc.valid, fc.op, fc.addr}, {1'b1, FL_ERASE_SECT, APP_BASE})
        rreg(OFS_LOCKBITS); `CHK(rd_v, 8'hFE)
        n = 0;
        do begin rreg(OFS_STATUS); n++; end
        while (rd_v[ST_CE_BUSY] !== 1'b0 && n < 50);
        if (rd_v[ST_CE_BUSY] !== 1'b0) error_cnt++;
        rreg(OFS_LOCKBITS); `CHK(rd_v, LOCK_RST)
        wrap_up();
    end
endmodule // tb
